// file: core/spmsp_pkg.sv
// Constants and types shared by the serial port master/slave block.
// Contract
// - With master enabled, writing the data register starts a transfer immediately.
// - Master sets transfer done flag when the last bit completes.
// - Master shifts frame length plus one bits; field resets to 111.
// - Master samples MISO while shifting MOSI; received byte replaces data.
// - Enabled with master clear acts as slave once select goes low.
// - Slave sets transfer done flag when slave select rises.
// - Slave select rising copies shift register to receive buffer unless overrun.
// - Slave data writes load shift register; otherwise old contents resend.
// - Data write during transfer is ignored and sets write collision flag.
// - Data reads return receive buffer; writes go straight to shift register.
// - Completion with unread buffer sets overrun and discards new byte.
// - Select low while master enabled sets mode fault, clears both enables.
// - Slave selected status reads 1 while select input is low.
// - Transmit busy reads 1 during a master transfer, cleared at end.
// - Clock phase 0 samples first edge; 1 samples second edge.
// - Clock polarity sets the idle level of the serial clock.
// - Read-only bit counter reports the bit just transmitted.
// - Master clock is system clock divided by twice the sum of divider and one.
// - Done, collision, fault and overrun flags raise interrupt; software clears.
// - Port enable turns the port on; resets to zero.
// - Both data lines shift most significant bit first.
// - MISO is high impedance when not selected as slave.
package spmsp_pkg;
  localparam logic [7:0] SPMSP_ADDR_CFG = 8'h9a;
  localparam logic [7:0] SPMSP_ADDR_DAT = 8'h9b;
  localparam logic [7:0] SPMSP_ADDR_CKR = 8'h9d;
  localparam logic [7:0] SPMSP_ADDR_CN = 8'hf8;
  localparam logic [7:0] SPMSP_CFG_RST = 8'h07;
  localparam logic [7:0] SPMSP_CKR_RST = 8'h00;
  localparam logic [7:0] SPMSP_CN_RST = 8'h00;
  localparam logic [7:0] SPMSP_DAT_RST = 8'h00;
  localparam int SPMSP_CN_DONE = 7;
  localparam int SPMSP_CN_WRITE_COLLISION_FLAG = 6;
  localparam int SPMSP_CN_MODE_FAULT_FLAG = 5;
  localparam int SPMSP_CN_OVR = 4;
  localparam int SPMSP_CN_BUSY = 3;
  localparam int SPMSP_CN_SEL = 2;
  localparam int SPMSP_CN_MST = 1;
  localparam int SPMSP_CN_EN = 0;
  localparam int SPMSP_CFG_PHA = 7;
  localparam int SPMSP_CFG_POL = 6;
  localparam int SPMSP_SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    SPMSP_IDLE = 2'b00,
    SPMSP_LEAD = 2'b01,
    SPMSP_TRAIL = 2'b11
  } spmsp_state_type;
endpackage : spmsp_pkg

// file: core/spmsp_port.sv
// Serial port master/slave core with its register file.
`timescale 1ns/1ps
`default_nettype none
module spmsp_port (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic slave_select_input_n,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  output logic irq
);
  import spmsp_pkg::*;
  typedef struct packed {
    spmsp_state_type st;
    logic [7:0] cfg;
    logic [7:0] ckr;
    logic [7:0] cn;
    logic [7:0] shift;
    logic [7:0] rxbuf;
    logic unread;
    logic [7:0] div;
    logic [2:0] cnt;
    logic sck;
    logic sck_old;
    logic nss_old;
    logic sampled;
    logic [7:0] rdata;
    logic mosi;
    logic miso;
    logic miso_oe_n;
    logic mosi_oe_n;
    logic sck_oe_n;
    logic irq;
  } spmsp_port_type;
  spmsp_port_type s_r;
  spmsp_port_type s_nxt;
  logic nss_n;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  spmsp_sync #(.RST_VAL(1'b1)) u_nss (.mclk(mclk), .reset(reset),
    .din(slave_select_input_n), .dout(nss_n));
  spmsp_sync #(.RST_VAL(1'b0)) u_sck (.mclk(mclk), .reset(reset),
    .din(sck_in), .dout(sck_s));
  spmsp_sync #(.RST_VAL(1'b0)) u_mosi (.mclk(mclk), .reset(reset),
    .din(mosi_in), .dout(mosi_s));
  spmsp_sync #(.RST_VAL(1'b0)) u_miso (.mclk(mclk), .reset(reset),
    .din(miso_in), .dout(miso_s));
  always_comb begin
    logic en;
    logic mst;
    logic pha;
    logic pol;
    logic slv;
    logic lead_edge;
    logic trail_edge;
    logic done;
    logic last;
    logic [7:0] newbyte;
    logic sck_lvl;
    en = s_r.cn[SPMSP_CN_EN];
    mst = s_r.cn[SPMSP_CN_MST];
    pha = s_r.cfg[SPMSP_CFG_PHA];
    pol = s_r.cfg[SPMSP_CFG_POL];
    slv = en && !mst && !nss_n;
    lead_edge = 1'b0;
    trail_edge = 1'b0;
    done = 1'b0;
    last = 1'b0;
    newbyte = s_r.shift;
    sck_lvl = sck_s ^ pol;
    s_nxt = s_r;
    s_nxt.nss_old = nss_n;
    s_nxt.sck_old = sck_lvl;
    s_nxt.cn[SPMSP_CN_SEL] = !nss_n;
    if (reg_rd && reg_addr == SPMSP_ADDR_DAT) begin
      s_nxt.unread = 1'b0;
    end
    unique case (s_r.st)
      SPMSP_IDLE: begin
        s_nxt.sck = pol;
        s_nxt.div = 8'h00;
      end
      SPMSP_LEAD, SPMSP_TRAIL: begin
        if (s_r.div == s_r.ckr) begin
          s_nxt.div = 8'h00;
          s_nxt.sck = !s_r.sck;
          if (s_r.st == SPMSP_LEAD) begin
            lead_edge = 1'b1;
            s_nxt.st = SPMSP_TRAIL;
          end else begin
            trail_edge = 1'b1;
            s_nxt.st = SPMSP_LEAD;
          end
        end else begin
          s_nxt.div = s_r.div + 8'h01;
        end
      end
      default: begin
        s_nxt.st = SPMSP_IDLE;
      end
    endcase
    // Master: first half clock idles the line so phase 0 data can settle.
    // sample edge
    if ((lead_edge && !pha) || (trail_edge && pha)) begin
      s_nxt.shift = {s_r.shift[6:0], miso_s};
      s_nxt.sampled = 1'b1;
    end
    // The sampled mark stays set for the rest of the frame, so phase 1
    // drives each new bit on the leading edge after the first capture.
    if ((trail_edge && !pha) || (lead_edge && pha && s_r.sampled)) begin
      s_nxt.mosi = s_nxt.shift[7];
    end
    if (trail_edge) begin
      s_nxt.cfg[5:3] = s_r.cnt;
      if (s_r.cnt == s_r.cfg[2:0]) begin
        last = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 3'd1;
      end
    end
    if (last) begin
      s_nxt.st = SPMSP_IDLE;
      s_nxt.sck = pol;
      done = 1'b1;
      newbyte = s_nxt.shift;
      s_nxt.cn[SPMSP_CN_BUSY] = 1'b0;
    end
    // Slave: shift on synchronised clock edges of the external master.
    if (slv && s_r.st == SPMSP_IDLE && sck_lvl != s_r.sck_old) begin
      if (sck_lvl ^ pha) begin
        s_nxt.shift = {s_r.shift[6:0], mosi_s};
        s_nxt.cfg[5:3] = s_r.cnt;
        s_nxt.cnt = s_r.cnt + 3'd1;
      end else begin
        s_nxt.mosi = 1'b0;
        s_nxt.miso = s_r.shift[7];
      end
    end
    if (slv && nss_n != s_r.nss_old) begin
      s_nxt.miso = s_r.shift[7];
      s_nxt.cnt = 3'd0;
    end
    if (en && !mst && nss_n && !s_r.nss_old) begin
      done = 1'b1;
      newbyte = s_r.shift;
      s_nxt.cnt = 3'd0;
    end
    if (done) begin
      if (s_r.unread) begin
        s_nxt.cn[SPMSP_CN_OVR] = 1'b1;
      end else begin
        s_nxt.rxbuf = newbyte;
        s_nxt.unread = 1'b1;
      end
      s_nxt.cn[SPMSP_CN_DONE] = 1'b1;
    end
    // Register writes; hardware flag sets in the same cycle take priority over clears.
    if (reg_wr) begin
      unique case (reg_addr)
        SPMSP_ADDR_CFG: begin
          s_nxt.cfg = {reg_wdata[7:6], s_nxt.cfg[5:3], reg_wdata[2:0]};
        end
        SPMSP_ADDR_CKR: begin
          s_nxt.ckr = reg_wdata;
        end
        SPMSP_ADDR_CN: begin
          s_nxt.cn = {reg_wdata[7:4] | (s_nxt.cn[7:4] & {done, 1'b0,
            1'b0, done && s_r.unread}), s_nxt.cn[3:2], reg_wdata[1:0]};
        end
        SPMSP_ADDR_DAT: begin
          if (s_r.st != SPMSP_IDLE || slv && s_r.cnt != 3'd0) begin
            s_nxt.cn[SPMSP_CN_WRITE_COLLISION_FLAG] = 1'b1;
          end else if (en && mst) begin
            s_nxt.shift = reg_wdata;
            s_nxt.mosi = reg_wdata[7];
            s_nxt.st = SPMSP_LEAD;
            s_nxt.cnt = 3'd0;
            s_nxt.sampled = 1'b0;
            s_nxt.cn[SPMSP_CN_BUSY] = 1'b1;
          end else begin
            s_nxt.shift = reg_wdata;
            s_nxt.miso = reg_wdata[7];
          end
        end
        default: begin
        end
      endcase
    end
    if (mst && !nss_n) begin
      s_nxt.cn[SPMSP_CN_MODE_FAULT_FLAG] = 1'b1;
      s_nxt.cn[SPMSP_CN_MST] = 1'b0;
      s_nxt.cn[SPMSP_CN_EN] = 1'b0;
      s_nxt.cn[SPMSP_CN_BUSY] = 1'b0;
      s_nxt.st = SPMSP_IDLE;
      s_nxt.sck = pol;
    end
    if (!s_nxt.cn[SPMSP_CN_EN]) begin
      s_nxt.st = SPMSP_IDLE;
      s_nxt.cn[SPMSP_CN_BUSY] = 1'b0;
    end
    if (s_nxt.st == SPMSP_IDLE) begin
      s_nxt.sck = s_nxt.cfg[SPMSP_CFG_POL];
    end
    s_nxt.sck_oe_n = !(s_nxt.cn[SPMSP_CN_EN] && s_nxt.cn[SPMSP_CN_MST]);
    s_nxt.mosi_oe_n = s_nxt.sck_oe_n;
    s_nxt.miso_oe_n = !(s_nxt.cn[SPMSP_CN_EN] && !s_nxt.cn[SPMSP_CN_MST]
      && !nss_n);
    s_nxt.irq = |s_nxt.cn[7:4];
    unique case (reg_addr)
      SPMSP_ADDR_CFG: s_nxt.rdata = s_r.cfg;
      SPMSP_ADDR_CKR: s_nxt.rdata = s_r.ckr;
      SPMSP_ADDR_CN: s_nxt.rdata = s_r.cn;
      SPMSP_ADDR_DAT: s_nxt.rdata = s_r.rxbuf;
      default: s_nxt.rdata = 8'h00;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '0;
      s_r.st <= SPMSP_IDLE;
      s_r.cfg <= SPMSP_CFG_RST;
      s_r.ckr <= SPMSP_CKR_RST;
      s_r.cn <= SPMSP_CN_RST;
      s_r.shift <= SPMSP_DAT_RST;
      s_r.rxbuf <= SPMSP_DAT_RST;
      s_r.nss_old <= 1'b1;
      s_r.sck_oe_n <= 1'b1;
      s_r.mosi_oe_n <= 1'b1;
      s_r.miso_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign reg_rdata = s_r.rdata;
  assign sck_out = s_r.sck;
  assign sck_oe_n = s_r.sck_oe_n;
  assign mosi_out = s_r.mosi;
  assign mosi_oe_n = s_r.mosi_oe_n;
  assign miso_out = s_r.miso;
  assign miso_oe_n = s_r.miso_oe_n;
  assign irq = s_r.irq;
endmodule : spmsp_port
`default_nettype wire

// file: core/spmsp_sync.sv
// Three-stage input synchroniser with agreement on the last two stages.
`timescale 1ns/1ps
`default_nettype none
module spmsp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  import spmsp_pkg::*;
  typedef struct packed {
    logic [SPMSP_SYNC_STAGES-1:0] stg;
    logic out;
  } spmsp_sync_type;
  spmsp_sync_type s_r;
  spmsp_sync_type s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.stg = {s_r.stg[SPMSP_SYNC_STAGES-2:0], din};
    // A change is accepted only when the second and third stages agree.
    if (s_r.stg[1] == s_r.stg[2]) begin
      s_nxt.out = s_r.stg[2];
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= {{SPMSP_SYNC_STAGES{RST_VAL}}, RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign dout = s_r.out;
endmodule : spmsp_sync
`default_nettype wire

// file: verification/spi_master_slave_port_bench.sv
// Self-checking bench for the serial port block.
`timescale 1ns/1ps
`default_nettype none
bind spmsp_port spmsp_sva spmsp_sva_i (.mclk(mclk), .reset(reset),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .slave_select_input_n(slave_select_input_n),
  .sck_oe_n(sck_oe_n), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n),
  .irq(irq));
module spi_master_slave_port_bench;
  import spmsp_pkg::*;
  typedef struct {logic [7:0] cfg, ckr, tx, sb;} spmsp_row_type;
  logic mclk, reset, reg_wr, reg_rd, ssn, tsck, tmosi, cs_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx, rx, rd, got, cfgv;
  logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, irq;
  logic sck_w, mosi_w, miso_w, mmiso;
  int n_mismatch, check_count, edges;
  time half, last;
  spmsp_row_type rows [4] = '{'{8'h07, 8'h04, 8'ha5, 8'h3c},
    '{8'h46, 8'h05, 8'h5a, 8'hc3}, '{8'h83, 8'h04, 8'hf0, 8'h96},
    '{8'hc0, 8'h06, 8'h81, 8'h7e}};
  assign sck_w = sck_oe_n ? tsck : sck_out;
  assign mosi_w = mosi_oe_n ? tmosi : mosi_out;
  assign miso_w = miso_oe_n ? mmiso : miso_out;
  spmsp_port spmsp_port_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .slave_select_input_n(ssn), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .irq(irq));
  spmsp_slave_model spmsp_slave_model_i (.cs_n(cs_n), .sck(sck_w),
    .mosi(mosi_w), .pol(cfgv[6]), .pha(cfgv[7]), .tx_byte(tx),
    .miso(mmiso), .rx_byte(rx));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(sck_out) begin
    edges++;
    half = $time - last;
    last = $time;
  end
  task automatic chk(input logic [7:0] g, e, input string m);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    rd = reg_rdata;
  endtask : rdr
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic wait_done();
    for (int i = 0; i < 300; i++) begin
      rdr(SPMSP_ADDR_CN);
      if (rd[7] === 1'b1) return;
    end
    n_mismatch++;
    complete_run();
  endtask : wait_done
  task automatic xfer(input spmsp_row_type r, input logic coll);
    int n;
    logic [7:0] mask;
    n = r.cfg[2:0] + 1;
    mask = 8'hff >> (8 - n);
    wr(SPMSP_ADDR_CN, 8'h00);
    cfgv = r.cfg;
    wr(SPMSP_ADDR_CFG, r.cfg);
    wr(SPMSP_ADDR_CKR, r.ckr);
    wr(SPMSP_ADDR_CN, 8'h03);
    tx = r.sb;
    cs_n = 1'b0;
    edges = 0;
    wr(SPMSP_ADDR_DAT, r.tx);
    if (coll) begin
      wr(SPMSP_ADDR_DAT, ~r.tx);
      rdr(SPMSP_ADDR_CN);
      chk(rd & 8'h08, 8'h08, "busy");
    end
    wait_done();
    chk(sck_out, cfgv[6], "idle level");
    chk(8'(edges), 8'(2 * n), "edge count");
    chk(8'(half / 100), r.ckr + 8'h01, "half period");
    chk(rx & mask, r.tx >> (8 - n), "slave got");
    chk(rd, {1'b1, coll, 6'h03}, "status");
    rdr(SPMSP_ADDR_DAT);
    chk(rd & mask, (r.sb >> (8 - n)) & mask, "master got");
    chk(irq, 1'b1, "irq");
    cs_n = 1'b1;
  endtask : xfer
  task automatic sbyte(input logic [7:0] b);
    ssn = 1'b0;
    repeat (8) @(negedge mclk);
    for (int i = 7; i >= 0; i--) begin
      tmosi = b[i];
      repeat (5) @(negedge mclk);
      tsck = 1'b1;
      got = {got[6:0], miso_w};
      repeat (5) @(negedge mclk);
      tsck = 1'b0;
    end
    repeat (5) @(negedge mclk);
    ssn = 1'b1;
    tmosi = ~tmosi;
    repeat (8) @(negedge mclk);
  endtask : sbyte
  initial begin
    {reset, reg_wr, reg_rd, tsck, tmosi} = 5'h10;
    {reg_addr, reg_wdata, cfgv, tx} = 32'h0;
    {ssn, cs_n, n_mismatch, check_count, edges, last} = '1;
    {n_mismatch, check_count} = '0;
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    repeat (5) @(negedge mclk);
    rdr(SPMSP_ADDR_CFG);
    chk(rd, 8'h07, "cfg reset");
    rdr(SPMSP_ADDR_CKR);
    chk(rd, 8'h00, "divider reset");
    rdr(SPMSP_ADDR_CN);
    chk(rd, 8'h00, "ctrl reset");
    rdr(8'h9c);
    chk(rd, 8'h00, "unmapped");
    $display("reset test done");
    foreach (rows[i]) begin
      xfer(rows[i], 1'b0);
      $display("row %0d done", i);
    end
    xfer(rows[0], 1'b1);
    $display("collision test done");
    wr(SPMSP_ADDR_CN, 8'h00);
    cfgv = 8'h07;
    wr(SPMSP_ADDR_CFG, 8'h07);
    wr(SPMSP_ADDR_CN, 8'h01);
    wr(SPMSP_ADDR_DAT, 8'h69);
    sbyte(8'hc5);
    chk(got, 8'h69, "slave sent");
    rdr(SPMSP_ADDR_CN);
    chk(rd, 8'h81, "slave done");
    rdr(SPMSP_ADDR_DAT);
    chk(rd, 8'hc5, "slave buffer");
    ssn = 1'b0;
    repeat (6) @(negedge mclk);
    rdr(SPMSP_ADDR_CN);
    chk(rd & 8'h04, 8'h04, "selected");
    sbyte(8'h3a);
    sbyte(8'h5e);
    rdr(SPMSP_ADDR_CN);
    chk(rd & 8'h90, 8'h90, "overrun");
    rdr(SPMSP_ADDR_DAT);
    chk(rd, 8'h3a, "old kept");
    $display("slave test done");
    wr(SPMSP_ADDR_CN, 8'h00);
    wr(SPMSP_ADDR_CN, 8'h03);
    ssn = 1'b0;
    repeat (10) @(negedge mclk);
    rdr(SPMSP_ADDR_CN);
    chk(rd & 8'h23, 8'h20, "mode fault");
    chk(irq, 1'b1, "fault irq");
    ssn = 1'b1;
    $display("fault test done");
    complete_run();
  end
endmodule : spi_master_slave_port_bench
`default_nettype wire

// file: verification/spmsp_slave_model.sv
// Behavioural slave device on the far side of the serial bus.
`timescale 1ns/1ps
`default_nettype none
module spmsp_slave_model (
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic pol,
  input wire logic pha,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [7:0] sr;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    sr = 8'h00;
  end
  always @(negedge cs_n) begin
    sr = tx_byte;
    miso = sr[7];
  end
  // Released line flips so stale data never passes as valid.
  always @(posedge cs_n) miso = ~miso;
  always @(sck) begin
    if (!cs_n && (sck ^ pol ^ pha)) begin
      rx_byte = {rx_byte[6:0], mosi};
    end else if (!cs_n) begin
      if (!pha) sr = {sr[6:0], 1'b0};
      miso = sr[7];
      if (pha) sr = {sr[6:0], 1'b0};
    end
  end
endmodule : spmsp_slave_model
`default_nettype wire

// file: verification/spmsp_sva.sv
// Port-level assertions for the serial port block.
`timescale 1ns/1ps
`default_nettype none
module spmsp_sva
  import spmsp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic slave_select_input_n,
  input wire logic sck_oe_n,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n,
  input wire logic irq
);
  logic ctrl_wr;
  logic unmapped;
  assign ctrl_wr = reg_wr && (reg_addr == SPMSP_ADDR_CN);
  assign unmapped = !(reg_addr inside {SPMSP_ADDR_CFG, SPMSP_ADDR_DAT,
                                       SPMSP_ADDR_CKR, SPMSP_ADDR_CN});
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  rst_pins_a: assert property (disable iff (1'b0) reset |=> sck_oe_n &&
    mosi_oe_n && miso_oe_n && !irq && reg_rdata == 8'h00)
    else $error("outputs active after reset");
  miso_hiz_a: assert property (slave_select_input_n [*6] |-> miso_oe_n)
    else $error("miso driven while not selected");
  mode_fault_a: assert property ((!slave_select_input_n) [*8] |-> sck_oe_n)
    else $error("master kept clock with select low");
  lane_pair_a: assert property (sck_oe_n == mosi_oe_n)
    else $error("clock and data enables differ");
  slave_input_a: assert property (!miso_oe_n |-> sck_oe_n)
    else $error("slave drives clock");
  flag_hold_a: assert property ($fell(irq) |->
    $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("request dropped without software clear");
  unmapped_rd_a: assert property ($past(unmapped) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  master_on_a: assert property (ctrl_wr && reg_wdata == 8'h03 &&
    slave_select_input_n |-> ##[1:2] !sck_oe_n)
    else $error("master enable did not drive clock");
  cover property ($fell(miso_oe_n));
  cover property ($rose(irq));
  cover property (!sck_oe_n ##1 sck_oe_n);
endmodule : spmsp_sva
`default_nettype wire
